//--- dv/bpu_sched_model.sv
`timescale 1ns/1ps
`default_nettype none

// scheduler stand-in: keeps tags of accepted conditional branches, resolves in order
module bpu_sched_model
    import bpu_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire bpu_dec_t dec,
    input wire logic decStall,
    input wire bpu_tag_t decTag,
    input wire logic mispredict,
    input wire logic req,
    input wire logic taken,
    input wire logic [ADDR_W-1:0] target,
    input wire logic [ADDR_W-1:0] nextPc,
    output var bpu_res_t res
);
    bpu_tag_t tagQ[$];
    logic pend;

    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            res <= '0;
            pend <= 1'b0;
            tagQ.delete();
        end else begin
            // tag is registered, so it is taken one edge after acceptance
            if (pend) tagQ.push_back(decTag);
            // a decode beside a wrong resolve is dropped by the unit, so no tag follows it
            pend <= dec.valid && (dec.kind inside {BPU_JCC, BPU_LOOP}) && !decStall
                && !(res.valid && res.taken != res.tag.predTaken);
            // a flush empties the scheduler of every younger branch
            if (mispredict) tagQ.delete();
            if (req && tagQ.size() > 0) begin
                res <= '{1'b1, taken, tagQ.pop_front(), target, nextPc};
            end else begin
                // idle fields toggle so stale values never look valid
                res <= '{1'b0, ~res.taken, ~res.tag, ~res.target, ~res.nextPc};
            end
        end
    end
endmodule // bpu_sched_model

`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import bpu_pkg::*;

    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    bpu_dec_t dec = '0;
    bpu_fill_t fill = '0;
    bpu_res_t res;
    logic req = 1'b0;
    logic taken = 1'b0;
    logic [ADDR_W-1:0] target = '0;
    logic [ADDR_W-1:0] resNext = '0;
    logic decStall, mispredict, restoreRegs, flushYounger, commitHold, rasMiss;
    bpu_tag_t decTag;
    bpu_redir_t redir;
    int errors = 0;
    int compares = 0;
    int cycles = 0;

    always #12.5 clk_sys = ~clk_sys;

    bpu_branch_unit u_bpu_branch_unit (.clk_sys(clk_sys), .reset(reset), .dec(dec),
        .res(res), .fill(fill), .decStall(decStall), .decTag(decTag), .redir(redir),
        .mispredict(mispredict), .restoreRegs(restoreRegs), .flushYounger(flushYounger),
        .commitHold(commitHold), .rasMiss(rasMiss));

    bpu_sched_model u_bpu_sched_model (.clk_sys(clk_sys), .reset(reset), .dec(dec),
        .decStall(decStall), .decTag(decTag), .mispredict(mispredict), .req(req),
        .taken(taken), .target(target), .nextPc(resNext), .res(res));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // one decode; returns just after the edge that launches the answer
    task automatic offer(input bpu_kind_t k, input logic [31:0] p, n, d);
        @(posedge clk_sys) dec <= '{1'b1, k, p, n, d};
        @(posedge clk_sys) dec.valid <= 1'b0;
        #1;
    endtask

    task automatic resolve(input logic t, input logic [31:0] tg, np);
        @(posedge clk_sys) begin
            req <= 1'b1;
            taken <= t;
            target <= tg;
            resNext <= np;
        end
        @(posedge clk_sys) req <= 1'b0;
        @(posedge clk_sys) #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_not_taken();
        offer(BPU_JCC, 32'h0000_0100, 32'h0000_0102, 32'h0000_0040);
        chk(redir.valid, 1'b0);
        chk(decTag, {1'b0, 13'h0100, 13'h0000});
        chk(commitHold, 1'b1);
        resolve(1'b0, 32'h0000_0142, 32'h0000_0102);
        chk(mispredict, 1'b0);
        chk(commitHold, 1'b0);
        $display("test not_taken done");
    endtask

    task automatic t_jump_cache();
        logic [127:0] line;
        line = 128'h0F1E_2D3C_4B5A_6978_8796_A5B4_C3D2_E1F0;
        offer(BPU_JMP, 32'h0000_2000, 32'h0000_2005, 32'h0000_102B);
        chk(redir.valid, 1'b1);
        chk(redir.pc, 32'h0000_3030);
        chk(redir.fromBtc, 1'b0);
        @(posedge clk_sys) fill <= '{1'b1, 32'h0000_3030, line};
        @(posedge clk_sys) fill.valid <= 1'b0;
        offer(BPU_JMP, 32'h0000_2000, 32'h0000_2005, 32'h0000_102B);
        chk(redir.fromBtc, 1'b1);
        chk(redir.bytes, line);
        @(posedge clk_sys) #1;
        chk(redir.valid, 1'b0);
        $display("test jump_cache done");
    endtask

    task automatic t_call_ret();
        offer(BPU_CALL, 32'h0000_4000, 32'h0000_4005, 32'h0000_0FFB);
        chk(redir.pc, 32'h0000_5000);
        offer(BPU_RET, 32'h0000_5010, 32'h0000_5011, 32'h0000_0000);
        chk(redir.valid, 1'b1);
        chk(redir.pc, 32'h0000_4005);
        chk(rasMiss, 1'b0);
        offer(BPU_RET, 32'h0000_5020, 32'h0000_5021, 32'h0000_0000);
        chk(rasMiss, 1'b1);
        $display("test call_ret done");
    endtask

    task automatic t_limit_flush();
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys) dec <= '{1'b1, (i % 2) ? BPU_LOOP : BPU_JCC, 32'h0000_0600 + 32'(i * 16),
                32'h0000_0602 + 32'(i * 16), 32'h0000_0080};
        end
        #1;
        chk(decStall, 1'b1);
        @(posedge clk_sys) dec.valid <= 1'b0;
        #1;
        chk(commitHold, 1'b1);
        // first in flight was wrongly guessed not taken
        resolve(1'b1, 32'h0000_0680, 32'h0000_0602);
        chk(mispredict, 1'b1);
        chk(restoreRegs, 1'b1);
        chk(flushYounger, 1'b1);
        chk(redir.pc, 32'h0000_0680);
        chk(commitHold, 1'b0);
        @(posedge clk_sys) #1;
        chk(mispredict, 1'b0);
        // one taken outcome lifts the weak counter of entry 0x600; history is now 1
        offer(BPU_JCC, 32'h0000_0601, 32'h0000_0603, 32'h0000_0040);
        chk(redir.valid, 1'b1);
        chk(redir.pc, 32'h0000_0643);
        $display("test limit_flush done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // the whole run needs under forty cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            wrap_up();
        end
    end

    initial begin
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        t_not_taken();
        t_jump_cache();
        t_call_ret();
        t_limit_flush();
        wrap_up();
    end
endmodule // testbench

`default_nettype wire

//--- hdl/bpu_branch_unit.sv
`timescale 1ns/1ps
`default_nettype none

module bpu_branch_unit
    import bpu_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire bpu_dec_t dec,
    input wire bpu_res_t res,
    input wire bpu_fill_t fill,
    output logic decStall,
    output bpu_tag_t decTag,
    output bpu_redir_t redir,
    output logic mispredict,
    output logic restoreRegs,
    output logic flushYounger,
    output logic commitHold,
    output logic rasMiss
);

    bpu_state_t st_r;
    bpu_state_t st_nxt;
    logic [1:0] histTable [HIST_ENTRIES];

    logic isCond;
    logic decAccept;
    logic misNow;
    logic [HIST_IDX_W-1:0] lookIdx;
    logic predTaken;
    logic [ADDR_W-1:0] candTaken;
    logic [ADDR_W-1:0] candFall;
    logic [ADDR_W-1:0] rasTop;
    logic [1:0] oldCnt;
    logic [1:0] newCnt;
    logic [BTC_ENTRIES-1:0] hitVec;
    logic [BTC_ENTRIES-1:0] fillHitVec;
    logic btcHit;
    logic [BTC_LINE_W-1:0] btcBytes;
    logic [ADDR_W-1:0] selTarget;

    ////////////////////////////////////////////////////////////////////////////////
    // decode-side candidates and prediction

    assign isCond = (dec.kind == BPU_JCC) || (dec.kind == BPU_LOOP);
    assign misNow = res.valid && (res.taken != res.tag.predTaken);
    assign decStall = dec.valid && isCond && (st_r.inflight == MAX_INFLIGHT);
    // a decode in the cycle of a mispredict is younger work and is dropped
    assign decAccept = dec.valid && !decStall && !misNow;
    // both candidates exist before the kind is known; no target lives in the table
    assign candTaken = dec.nextPc + dec.disp;
    assign candFall = dec.nextPc;
    assign lookIdx = dec.pc[HIST_IDX_W-1:0] ^ st_r.ghist;
    assign predTaken = histTable[lookIdx][CNT_DIR_BIT];
    assign rasTop = st_r.ras[st_r.rasPtr - 4'h1];

    always_comb begin
        unique case (dec.kind)
            BPU_RET: selTarget = rasTop;
            BPU_JCC, BPU_LOOP: selTarget = predTaken ? candTaken : candFall;
            default: selTarget = candTaken;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // target cache lookup and fill match, two comparators per entry

    genvar gi;
    generate
        for (gi = 0; gi < BTC_ENTRIES; gi++) begin : g_btc
            assign hitVec[gi] = st_r.btc[gi].valid
                && (st_r.btc[gi].tag == selTarget[ADDR_W-1:BTC_TAG_LSB]);
            assign fillHitVec[gi] = st_r.btc[gi].valid
                && (st_r.btc[gi].tag == fill.addr[ADDR_W-1:BTC_TAG_LSB]);
        end
    endgenerate

    assign btcHit = |hitVec;

    always_comb begin
        btcBytes = '0;
        for (int i = 0; i < BTC_ENTRIES; i++) begin
            if (hitVec[i]) begin
                btcBytes = st_r.btc[i].bytes;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // history counter training

    assign oldCnt = histTable[res.tag.histIdx];
    always_comb begin
        newCnt = oldCnt;
        if (res.taken && oldCnt != CNT_MAX) begin
            newCnt = oldCnt + 2'h1;
        end else if (!res.taken && oldCnt != 2'h0) begin
            newCnt = oldCnt - 2'h1;
        end
    end

    // counters start weakly not-taken; the reset sweep costs area but avoids X predictions
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < HIST_ENTRIES; i++) begin
                histTable[i] <= CNT_RESET;
            end
        end else if (res.valid) begin
            histTable[res.tag.histIdx] <= newCnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        st_nxt = st_r;
        st_nxt.redir.valid = 1'b0;
        st_nxt.redir.fromBtc = 1'b0;
        st_nxt.mispredict = 1'b0;
        st_nxt.rasMiss = 1'b0;

        // branches resolve in order, so a correct one retires the oldest
        if (res.valid && !misNow && st_r.inflight != 3'h0) begin
            st_nxt.inflight = st_r.inflight - 3'h1;
        end

        if (fill.valid && !(|fillHitVec)) begin
            st_nxt.btc[st_r.btcVictim].valid = 1'b1;
            st_nxt.btc[st_r.btcVictim].tag = fill.addr[ADDR_W-1:BTC_TAG_LSB];
            st_nxt.btc[st_r.btcVictim].bytes = fill.bytes;
            st_nxt.btcVictim = st_r.btcVictim + 4'h1;
        end

        if (misNow) begin
            // everything in flight is younger than the wrong branch
            st_nxt.mispredict = 1'b1;
            st_nxt.inflight = 3'h0;
            st_nxt.ghist = {res.tag.histSnap[HIST_IDX_W-2:0], res.taken};
            st_nxt.redir.valid = 1'b1;
            st_nxt.redir.pc = res.taken ? res.target : res.nextPc;
        end else if (decAccept) begin
            unique case (dec.kind)
                BPU_JMP: begin
                    st_nxt.redir.valid = 1'b1;
                end
                BPU_CALL: begin
                    st_nxt.redir.valid = 1'b1;
                    st_nxt.ras[st_r.rasPtr] = candFall;
                    st_nxt.rasPtr = st_r.rasPtr + 4'h1;
                    if (st_r.rasCnt != RAS_FULL) begin
                        st_nxt.rasCnt = st_r.rasCnt + 5'h1;
                    end
                end
                BPU_RET: begin
                    if (st_r.rasCnt != 5'h0) begin
                        st_nxt.redir.valid = 1'b1;
                        st_nxt.rasPtr = st_r.rasPtr - 4'h1;
                        st_nxt.rasCnt = st_r.rasCnt - 5'h1;
                    end else begin
                        st_nxt.rasMiss = 1'b1;
                    end
                end
                BPU_JCC, BPU_LOOP: begin
                    st_nxt.inflight = st_nxt.inflight + 3'h1;
                    st_nxt.ghist = {st_r.ghist[HIST_IDX_W-2:0], predTaken};
                    st_nxt.decTag.predTaken = predTaken;
                    st_nxt.decTag.histIdx = lookIdx;
                    st_nxt.decTag.histSnap = st_r.ghist;
                    st_nxt.redir.valid = predTaken;
                end
                default: begin
                end
            endcase
            st_nxt.redir.pc = selTarget;
            st_nxt.redir.fromBtc = btcHit && st_nxt.redir.valid;
            st_nxt.redir.bytes = btcBytes;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign redir = st_r.redir;
    assign decTag = st_r.decTag;
    assign mispredict = st_r.mispredict;
    assign restoreRegs = st_r.mispredict;
    assign flushYounger = st_r.mispredict;
    assign commitHold = (st_r.inflight != 3'h0);
    assign rasMiss = st_r.rasMiss;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    notTakenSeq_a: assert property (
        decAccept && isCond && !predTaken |=> !redir.valid)
        else $error("not-taken branch redirected fetch");
    jmpRedirect_a: assert property (
        decAccept && dec.kind == BPU_JMP |=> redir.valid && redir.pc == $past(candTaken))
        else $error("jump did not redirect to adder target");
    takenTarget_a: assert property (
        decAccept && isCond && predTaken |=> redir.valid && redir.pc == $past(candTaken))
        else $error("predicted-taken branch used wrong target");
    btcDeliver_a: assert property (
        decAccept && dec.kind == BPU_JMP && btcHit
        |=> redir.fromBtc && redir.bytes == $past(btcBytes))
        else $error("target cache hit not delivered");
    callRet_a: assert property (
        decAccept && dec.kind == BPU_CALL ##1 decAccept && dec.kind == BPU_RET
        |=> redir.valid && redir.pc == $past(dec.nextPc, 2))
        else $error("return address mismatch");
    rasEmpty_a: assert property (
        decAccept && dec.kind == BPU_RET && st_r.rasCnt == 5'h0 |=> !redir.valid && rasMiss)
        else $error("empty return stack redirected");
    rasBound_a: assert property (st_r.rasCnt <= RAS_FULL)
        else $error("return stack count overflow");
    commitGate_a: assert property (
        decAccept && isCond |=> commitHold)
        else $error("commit not held behind unresolved branch");
    inflightCap_a: assert property (
        st_r.inflight == MAX_INFLIGHT && dec.valid && isCond
        |-> decStall ##1 (mispredict || st_r.inflight >= MAX_INFLIGHT - 3'h1))
        else $error("eighth branch accepted");
    mispLatency_a: assert property (
        misNow |=> mispredict && flushYounger && restoreRegs && !commitHold
            && redir.pc == $past(res.taken ? res.target : res.nextPc))
        else $error("mispredict not recovered in one cycle");

    callCov_c: cover property (decAccept && dec.kind == BPU_CALL ##1 decAccept && dec.kind == BPU_RET);
    stallCov_c: cover property (decStall);
    mispCov_c: cover property (mispredict);
    btcCov_c: cover property (redir.fromBtc);

endmodule // bpu_branch_unit

`default_nettype wire

//--- hdl/bpu_pkg.sv
package bpu_pkg;

    localparam int HIST_ENTRIES = 8192;
    localparam int HIST_IDX_W = 13;
    localparam int BTC_ENTRIES = 16;
    localparam int BTC_IDX_W = 4;
    localparam int BTC_LINE_BYTES = 16;
    localparam int BTC_LINE_W = BTC_LINE_BYTES * 8;
    localparam int RAS_DEPTH = 16;
    localparam int RAS_PTR_W = 4;
    localparam int RAS_CNT_W = 5;
    localparam logic [RAS_CNT_W-1:0] RAS_FULL = 5'h10;
    localparam logic [2:0] MAX_INFLIGHT = 3'h7;
    localparam logic [1:0] CNT_RESET = 2'h1;
    localparam logic [1:0] CNT_MAX = 2'h3;
    localparam int CNT_DIR_BIT = 1;
    localparam int ADDR_W = 32;
    localparam int BTC_TAG_LSB = 4;

    typedef enum logic [2:0] {
        BPU_NONE,
        BPU_JCC,
        BPU_LOOP,
        BPU_JMP,
        BPU_CALL,
        BPU_RET
    } bpu_kind_t;

    // one decoded branch offered by the decoders
    typedef struct packed {
        logic valid;
        bpu_kind_t kind;
        logic [ADDR_W-1:0] pc;
        logic [ADDR_W-1:0] nextPc;
        logic [ADDR_W-1:0] disp;
    } bpu_dec_t;

    // prediction tag that travels with a conditional branch to its resolution
    typedef struct packed {
        logic predTaken;
        logic [HIST_IDX_W-1:0] histIdx;
        logic [HIST_IDX_W-1:0] histSnap;
    } bpu_tag_t;

    // evaluated condition from the scheduler
    typedef struct packed {
        logic valid;
        logic taken;
        bpu_tag_t tag;
        logic [ADDR_W-1:0] target;
        logic [ADDR_W-1:0] nextPc;
    } bpu_res_t;

    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] addr;
        logic [BTC_LINE_W-1:0] bytes;
    } bpu_fill_t;

    // fetch redirect, optionally carrying the first target line
    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] pc;
        logic fromBtc;
        logic [BTC_LINE_W-1:0] bytes;
    } bpu_redir_t;

    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:BTC_TAG_LSB] tag;
        logic [BTC_LINE_W-1:0] bytes;
    } bpu_btc_ent_t;

    typedef struct packed {
        logic [HIST_IDX_W-1:0] ghist;
        logic [2:0] inflight;
        logic [RAS_PTR_W-1:0] rasPtr;
        logic [RAS_CNT_W-1:0] rasCnt;
        logic [RAS_DEPTH-1:0][ADDR_W-1:0] ras;
        logic [BTC_IDX_W-1:0] btcVictim;
        bpu_btc_ent_t [BTC_ENTRIES-1:0] btc;
        bpu_redir_t redir;
        bpu_tag_t decTag;
        logic mispredict;
        logic rasMiss;
    } bpu_state_t;

endpackage
